/* hdl/sbsel_pkg.sv */
// constants and types for the system bus select and cascade decode block
// Overview of operation
// - memory cycle addresses inside a system window go to the system bus, else local
// - bus choice is latched at cycle start and held until the cycle ends
// - all-local interrupt routing sends every acknowledge to the local bus
// - all-system interrupt routing sends every acknowledge to system bus, no decode
// - an interrupt request is answered by exactly two acknowledge cycles
// - second acknowledge reads an 8-bit vector over the data bus
// - in mixed routing the three slave pick lines decide the bus
// - system acknowledge first requests the arbiter, then enables system buffers
// - slave pick lines drive address lines A8, A9, A10 through tri-state outputs
// - decode adds at most 30 ns before bus choice is valid
// - first acknowledge gets at least 4 wait states before it may end
// - local choice ends first acknowledge at once; system choice extends it
// - command delay acts as repeated select while local command enable stays high
// - a system bus operation ends only on transfer acknowledge
// - cascade gate asserts in second acknowledge, one clock longer than address strobe
// - cascade gate asserts only during acknowledge cycles
// - system bus address and data are carried inverted, active low
// - a strap selects system bus mode; without it nothing goes to system bus
package sbsel_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int CAS_SETTLE_NS = 565;
  localparam int DECODE_NS = 30;
  localparam int MIN_ACK1_WAITS = 4;
  localparam int SETTLE_CYC = (CAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DECODE_CYC = (DECODE_NS / CLK_PERIOD_NS) < 1 ? 1 : DECODE_NS / CLK_PERIOD_NS;
  localparam int ACK1_WAIT_CYC = SETTLE_CYC > MIN_ACK1_WAITS ? SETTLE_CYC : MIN_ACK1_WAITS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] ACK1_WAIT_CNT = CNT_W'(ACK1_WAIT_CYC);
  localparam logic [1:0] ACK2_PH_MCE_OFF = 2'h1;
  localparam logic [1:0] ACK2_PH_DONE = 2'h2;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int VEC_W = 8;
  localparam int CAS_W = 3;
  localparam int NUM_WIN = 2;
  localparam int NUM_SLAVES = 8;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IRQ_ALL_LOCAL = 2'h0,
    IRQ_ALL_SYSTEM = 2'h1,
    IRQ_MIXED = 2'h2
  } irq_route_t;
  typedef struct packed {
    logic enable;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] limit;
  } mem_window_t;
  typedef struct packed {
    logic start;
    logic io;
    logic [ADDR_W-1:0] addr;
  } bus_cycle_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_MEM = 3'h1,
    ST_ACK1 = 3'h3,
    ST_ACK1_ARB = 3'h2,
    ST_ACK1_SYS = 3'h6,
    ST_ACK2 = 3'h7
  } state_t;
endpackage

/* hdl/system_bus_select_decode.sv */
// bus select, cascade decode and acknowledge sequencing for the system bus bridge
module system_bus_select_decode (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sys_mode_strap,
  input wire sbsel_pkg::bus_cycle_t cyc_req,
  input wire sbsel_pkg::mem_window_t [sbsel_pkg::NUM_WIN-1:0] windows,
  input wire sbsel_pkg::irq_route_t irq_route,
  input wire logic [sbsel_pkg::NUM_SLAVES-1:0] sys_slave_mask,
  input wire logic interrupt_request_input,
  input wire logic [sbsel_pkg::CAS_W-1:0] slave_pick_n,
  input wire logic local_ready,
  input wire logic [sbsel_pkg::DATA_W-1:0] local_data,
  input wire logic [sbsel_pkg::DATA_W-1:0] sys_data_n,
  input wire logic xack_n,
  input wire logic arb_grant,
  output logic cyc_done_q,
  output logic [sbsel_pkg::DATA_W-1:0] rd_data_q,
  output logic [sbsel_pkg::VEC_W-1:0] vector_q,
  output logic vector_valid_q,
  output logic [sbsel_pkg::ADDR_W-1:0] sys_addr_n_q,
  output logic ale_q,
  output logic interrupt_ack_cycle_q,
  output logic local_command_enable_q,
  output logic system_resident_bus_select_q,
  output logic command_delay_select_q,
  output logic bus_request_q,
  output logic sys_buf_en_q,
  output logic master_cascade_gate_q,
  output logic [sbsel_pkg::CAS_W-1:0] cascade_addr_n_q,
  output logic cascade_addr_oe_q
);
  import sbsel_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic window_hit(input logic [ADDR_W-1:0] a,
                                      input mem_window_t [NUM_WIN-1:0] w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_WIN; i++) begin
      if (w[i].enable && a >= w[i].base && a <= w[i].limit) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic route_decode(input irq_route_t r,
                                        input logic [NUM_SLAVES-1:0] mask,
                                        input logic [CAS_W-1:0] pick_n);
    logic sys;
    sys = 1'b0;
    unique case (r)
      IRQ_ALL_LOCAL: sys = 1'b0;
      IRQ_ALL_SYSTEM: sys = 1'b1;
      IRQ_MIXED: sys = mask[~pick_n];
      default: sys = 1'b0;
    endcase
    return sys;
  endfunction

  state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0] ph_q;
  logic route_q;
  logic strap_q;
  logic strap_taken_q;
  logic [CAS_W-1:0] pick_q;
  logic win_hit;
  logic ack_route;
  logic decide_now;
  logic mem_end;
  logic ack2_end;
  logic [VEC_W-1:0] vec_src;

  // ---------------------------------------------------------------
  // strap capture after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_q <= 1'b0;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_q <= sys_mode_strap;
      strap_taken_q <= 1'b1;
    end
  end

  // pick code is sampled every cycle; the decision only reads it after settling
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pick_q <= '1;
    end else begin
      pick_q <= slave_pick_n;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    win_hit = strap_q && !cyc_req.io && window_hit(cyc_req.addr, windows);
    ack_route = strap_q && route_decode(irq_route, sys_slave_mask, pick_q);
    // waiting out the settle time covers the controller's slow pick code
    decide_now = (state_q == ST_ACK1) && (cnt_q == ACK1_WAIT_CNT);
    mem_end = (state_q == ST_MEM) &&
              (system_resident_bus_select_q ? (sys_buf_en_q && !xack_n) : local_ready);
    ack2_end = (state_q == ST_ACK2) && (ph_q == ACK2_PH_DONE) &&
               (route_q ? !xack_n : local_ready);
    vec_src = route_q ? ~sys_data_n[VEC_W-1:0] : local_data[VEC_W-1:0];
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      ph_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          // acknowledge wins over a pending memory cycle
          if (interrupt_request_input) begin
            state_q <= ST_ACK1;
          end else if (cyc_req.start) begin
            state_q <= ST_MEM;
          end
        end
        ST_MEM: begin
          if (mem_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_ACK1: begin
          ph_q <= '0;
          if (decide_now) begin
            state_q <= ack_route ? ST_ACK1_ARB : ST_ACK2;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_ACK1_ARB: begin
          if (arb_grant) begin
            state_q <= ST_ACK1_SYS;
          end
        end
        ST_ACK1_SYS: begin
          ph_q <= '0;
          if (!xack_n) begin
            state_q <= ST_ACK2;
          end
        end
        ST_ACK2: begin
          if (ack2_end) begin
            state_q <= ST_IDLE;
          end else if (ph_q != ACK2_PH_DONE) begin
            ph_q <= ph_q + 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // acknowledge choice is made once and not revisited until the sequence ends
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      route_q <= 1'b0;
    end else if (decide_now) begin
      route_q <= ack_route;
    end
  end

  // ---------------------------------------------------------------
  // bus controller and arbiter controls
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ale_q <= 1'b0;
      cyc_done_q <= 1'b0;
      interrupt_ack_cycle_q <= 1'b0;
      local_command_enable_q <= 1'b0;
      system_resident_bus_select_q <= 1'b0;
      command_delay_select_q <= 1'b0;
      bus_request_q <= 1'b0;
      sys_buf_en_q <= 1'b0;
    end else begin
      ale_q <= 1'b0;
      cyc_done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (interrupt_request_input) begin
            interrupt_ack_cycle_q <= 1'b1;
            local_command_enable_q <= 1'b1;
            command_delay_select_q <= 1'b1;
            system_resident_bus_select_q <= 1'b0;
            ale_q <= 1'b1;
          end else if (cyc_req.start) begin
            local_command_enable_q <= !win_hit;
            system_resident_bus_select_q <= win_hit;
            bus_request_q <= win_hit;
            ale_q <= 1'b1;
          end
        end
        ST_MEM: begin
          if (system_resident_bus_select_q && arb_grant) begin
            sys_buf_en_q <= 1'b1;
          end
          if (mem_end) begin
            cyc_done_q <= 1'b1;
            bus_request_q <= 1'b0;
            sys_buf_en_q <= 1'b0;
            local_command_enable_q <= 1'b0;
            system_resident_bus_select_q <= 1'b0;
          end
        end
        ST_ACK1: begin
          if (decide_now) begin
            system_resident_bus_select_q <= ack_route;
            bus_request_q <= ack_route;
            if (!ack_route) begin
              command_delay_select_q <= 1'b0;
              cyc_done_q <= 1'b1;
              ale_q <= 1'b1;
            end
          end
        end
        ST_ACK1_ARB: begin
          // command start stays delayed until the arbiter hands over the bus
          if (arb_grant) begin
            sys_buf_en_q <= 1'b1;
            command_delay_select_q <= 1'b0;
          end
        end
        ST_ACK1_SYS: begin
          if (!xack_n) begin
            cyc_done_q <= 1'b1;
            ale_q <= 1'b1;
          end
        end
        ST_ACK2: begin
          if (ack2_end) begin
            cyc_done_q <= 1'b1;
            interrupt_ack_cycle_q <= 1'b0;
            local_command_enable_q <= 1'b0;
            system_resident_bus_select_q <= 1'b0;
            bus_request_q <= 1'b0;
            sys_buf_en_q <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // cascade gate onto A8..A10
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_cascade_gate_q <= 1'b0;
      cascade_addr_oe_q <= 1'b0;
      cascade_addr_n_q <= '1;
    end else if ((decide_now && !ack_route) || (state_q == ST_ACK1_SYS && !xack_n)) begin
      // only acknowledge transitions raise the gate; memory cycles never do
      master_cascade_gate_q <= 1'b1;
      cascade_addr_oe_q <= 1'b1;
      cascade_addr_n_q <= pick_q;
    end else if (state_q == ST_ACK2 && ph_q == ACK2_PH_MCE_OFF) begin
      master_cascade_gate_q <= 1'b0;
      cascade_addr_oe_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // address out and data capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= '0;
      vector_q <= '0;
      vector_valid_q <= 1'b0;
      sys_addr_n_q <= '1;
    end else begin
      vector_valid_q <= 1'b0;
      if (state_q == ST_IDLE && !interrupt_request_input && cyc_req.start && win_hit) begin
        sys_addr_n_q <= ~cyc_req.addr;
      end
      if (mem_end) begin
        rd_data_q <= system_resident_bus_select_q ? ~sys_data_n : local_data;
      end
      if (ack2_end) begin
        vector_q <= vec_src;
        vector_valid_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_mem_route;
    (state_q == ST_IDLE && cyc_req.start && !interrupt_request_input)
      |=> system_resident_bus_select_q == $past(win_hit);
  endproperty
  a_mem_route: assert property (p_mem_route) else $error("memory bus choice wrong");

  property p_hold;
    (state_q == ST_MEM) ##1 (state_q == ST_MEM) |-> $stable(system_resident_bus_select_q);
  endproperty
  a_hold: assert property (p_hold) else $error("bus choice changed mid cycle");

  property p_all_local;
    (decide_now && irq_route == IRQ_ALL_LOCAL) |=> !route_q && state_q == ST_ACK2;
  endproperty
  a_all_local: assert property (p_all_local) else $error("all-local ack left local");

  property p_all_sys;
    (decide_now && irq_route == IRQ_ALL_SYSTEM && strap_q) |=> route_q && bus_request_q;
  endproperty
  a_all_sys: assert property (p_all_sys) else $error("all-system ack not on system");

  property p_second_ack;
    (state_q == ST_ACK1_SYS && !xack_n) |=> state_q == ST_ACK2 && ale_q && cyc_done_q;
  endproperty
  a_second_ack: assert property (p_second_ack) else $error("second ack not started");

  property p_vector;
    ack2_end |=> vector_valid_q && vector_q == $past(vec_src);
  endproperty
  a_vector: assert property (p_vector) else $error("vector not captured");

  property p_decode;
    decide_now |=> route_q == $past(ack_route);
  endproperty
  a_decode: assert property (p_decode) else $error("decode late or wrong");

  property p_req_first;
    $rose(sys_buf_en_q) |-> $past(bus_request_q) && $past(arb_grant);
  endproperty
  a_req_first: assert property (p_req_first) else $error("buffers before grant");

  property p_cas_out;
    $rose(cascade_addr_oe_q) |-> cascade_addr_n_q == $past(pick_q) && interrupt_ack_cycle_q;
  endproperty
  a_cas_out: assert property (p_cas_out) else $error("cascade code not driven");

  property p_min_wait;
    $rose(interrupt_ack_cycle_q) |-> (!cyc_done_q)[*5];
  endproperty
  a_min_wait: assert property (p_min_wait) else $error("first ack too short");

  property p_local_end;
    (decide_now && !ack_route) |=> cyc_done_q;
  endproperty
  a_local_end: assert property (p_local_end) else $error("local ack not ended");

  property p_delay_sel;
    command_delay_select_q |-> local_command_enable_q && interrupt_ack_cycle_q;
  endproperty
  a_delay_sel: assert property (p_delay_sel) else $error("delay select without enable");

  property p_xack_end;
    ((state_q == ST_ACK1_SYS) || (state_q == ST_MEM && system_resident_bus_select_q)) && xack_n
      |=> !cyc_done_q;
  endproperty
  a_xack_end: assert property (p_xack_end) else $error("system op ended without ack");

  property p_mce;
    ($rose(ale_q) && state_q == ST_ACK2)
      |-> master_cascade_gate_q ##1 (!ale_q && master_cascade_gate_q) ##1 !master_cascade_gate_q;
  endproperty
  a_mce: assert property (p_mce) else $error("cascade gate timing wrong");

  property p_mce_only;
    master_cascade_gate_q |-> interrupt_ack_cycle_q;
  endproperty
  a_mce_only: assert property (p_mce_only) else $error("cascade gate outside ack");

  property p_strap;
    (strap_taken_q && !strap_q) |-> !system_resident_bus_select_q;
  endproperty
  a_strap: assert property (p_strap) else $error("system bus used without strap");

  property p_fixed;
    (interrupt_ack_cycle_q && !decide_now)
      |=> $stable(route_q) && (state_q != ST_ACK2 || system_resident_bus_select_q == route_q);
  endproperty
  a_fixed: assert property (p_fixed) else $error("ack route changed");
endmodule

/* tb/sysbus_partner.sv */
// far-side model: bus arbiter, system bus slave and master interrupt controller
module sysbus_partner (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic bus_request,
  input wire logic sys_buf_en,
  input wire logic cyc_done,
  input wire logic ack_active,
  input wire logic [sbsel_pkg::CAS_W-1:0] cas_code,
  input wire logic [sbsel_pkg::DATA_W-1:0] rdata,
  input wire logic [7:0] grant_dly,
  input wire logic [7:0] xack_dly,
  output logic arb_grant,
  output logic xack_n,
  output logic [sbsel_pkg::DATA_W-1:0] sys_data_n,
  output logic [sbsel_pkg::CAS_W-1:0] slave_pick_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import sbsel_pkg::*;
  // ---------------------------------------------------------------
  // timing of the far side
  // ---------------------------------------------------------------
  // code settles late but inside the limit, so an early decode sees noise
  localparam logic [7:0] PICK_LAG = 8'h3c;
  logic [7:0] gnt_cnt_q;
  logic [7:0] xack_cnt_q;
  logic [7:0] pick_cnt_q;
  logic [DATA_W-1:0] noise_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gnt_cnt_q <= 8'h00;
      arb_grant <= 1'b0;
    end else if (!bus_request) begin
      gnt_cnt_q <= 8'h00;
      arb_grant <= 1'b0;
    end else if (gnt_cnt_q >= grant_dly) begin
      arb_grant <= 1'b1;
    end else begin
      gnt_cnt_q <= gnt_cnt_q + 8'h01;
    end
  end

  // acknowledge held until the cycle is seen to end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      xack_cnt_q <= 8'h00;
      xack_n <= 1'b1;
    end else if (cyc_done || !sys_buf_en) begin
      xack_cnt_q <= 8'h00;
      xack_n <= 1'b1;
    end else if (xack_cnt_q >= xack_dly) begin
      xack_n <= 1'b0;
    end else begin
      xack_cnt_q <= xack_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pick_cnt_q <= 8'h00;
      noise_q <= 16'h0000;
    end else begin
      noise_q <= noise_q + 16'h1357;
      if (!ack_active) begin
        pick_cnt_q <= 8'h00;
      end else if (pick_cnt_q != PICK_LAG) begin
        pick_cnt_q <= pick_cnt_q + 8'h01;
      end
    end
  end

  assign slave_pick_n = (ack_active && pick_cnt_q == PICK_LAG) ? ~cas_code : noise_q[2:0];
  assign sys_data_n = !xack_n ? ~rdata : noise_q;
endmodule

/* tb/system_bus_select_decode_tb_top.sv */
// self-checking bench for the system bus select and cascade decode block
module system_bus_select_decode_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sbsel_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  localparam logic [15:0] LOC_RD = 16'ha5c3;
  localparam logic [15:0] SYS_RD = 16'h3c5a;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sys_mode_strap = 1'b0;
  bus_cycle_t cyc_req = '0;
  // window 1 is disabled yet covers everything, so it must never match
  mem_window_t [NUM_WIN-1:0] windows = {{1'b0, 24'h0, 24'hffffff}, {1'b1, 24'h100000, 24'h1fffff}};
  irq_route_t irq_route = IRQ_ALL_LOCAL;
  logic [7:0] sys_slave_mask = 8'h20;
  logic interrupt_request_input = 1'b0;
  logic local_ready = 1'b1;
  logic [15:0] local_data = LOC_RD;
  logic [2:0] cas_code = 3'h0;
  logic [7:0] grant_dly = 8'h02;
  logic [7:0] xack_dly = 8'h03;
  logic [2:0] slave_pick_n;
  logic [15:0] sys_data_n;
  logic xack_n, arb_grant, cyc_done_q, vector_valid_q, ale_q, interrupt_ack_cycle_q;
  logic local_command_enable_q, system_resident_bus_select_q, command_delay_select_q;
  logic bus_request_q, sys_buf_en_q, master_cascade_gate_q, cascade_addr_oe_q;
  logic [15:0] rd_data_q;
  logic [7:0] vector_q;
  logic [23:0] sys_addr_n_q;
  logic [2:0] cascade_addr_n_q;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;

  always #4 core_clk = ~core_clk;

  system_bus_select_decode i_dut (.core_clk, .arst_n, .sys_mode_strap, .cyc_req, .windows,
    .irq_route, .sys_slave_mask, .interrupt_request_input, .slave_pick_n, .local_ready,
    .local_data, .sys_data_n, .xack_n, .arb_grant, .cyc_done_q, .rd_data_q, .vector_q,
    .vector_valid_q, .sys_addr_n_q, .ale_q, .interrupt_ack_cycle_q, .local_command_enable_q,
    .system_resident_bus_select_q, .command_delay_select_q, .bus_request_q, .sys_buf_en_q,
    .master_cascade_gate_q, .cascade_addr_n_q, .cascade_addr_oe_q);

  sysbus_partner i_far (.core_clk, .arst_n, .bus_request(bus_request_q),
    .sys_buf_en(sys_buf_en_q), .cyc_done(cyc_done_q), .ack_active(interrupt_ack_cycle_q),
    .cas_code, .rdata(SYS_RD), .grant_dly, .xack_dly, .arb_grant, .xack_n, .sys_data_n,
    .slave_pick_n);

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      mismatches++;
      $display("ERROR %0t: run did not finish in time", $time);
      complete_run();
    end
  end

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset(input logic strap);
    arst_n = 1'b0;
    sys_mode_strap = strap;
    repeat (8) tick();
    chk(sys_addr_n_q === 24'hffffff && cascade_addr_n_q === 3'h7 && cyc_done_q === 1'b0
      && bus_request_q === 1'b0 && master_cascade_gate_q === 1'b0, "reset values");
    arst_n = 1'b1;
    repeat (2) tick();
  endtask

  task automatic do_mem(input logic [23:0] a, input logic io, input logic sys);
    int n;
    cyc_req = '{start: 1'b1, io: io, addr: a};
    tick();
    cyc_req.start = 1'b0;
    n = 0;
    while (ale_q !== 1'b1 && n < 3) begin
      tick();
      n++;
    end
    chk(ale_q === 1'b1 && system_resident_bus_select_q === sys
      && local_command_enable_q === ~sys, "bus choice");
    if (sys)
      chk(sys_addr_n_q === ~a && bus_request_q === 1'b1, "system address");
    while (cyc_done_q !== 1'b1 && n < 60) begin
      chk(system_resident_bus_select_q === sys && master_cascade_gate_q === 1'b0,
        "held choice");
      tick();
      n++;
    end
    chk(cyc_done_q === 1'b1 && rd_data_q === (sys ? SYS_RD : LOC_RD), "read data");
  endtask

  task automatic do_ack(input irq_route_t r, input logic [2:0] code, input logic sys,
                        input logic [7:0] vec);
    int n, w1, dones, gates, vv, req_at, buf_at;
    n = 0;
    w1 = 0;
    dones = 0;
    gates = 0;
    vv = 0;
    req_at = -1;
    buf_at = -1;
    irq_route = r;
    cas_code = code;
    interrupt_request_input = 1'b1;
    while (interrupt_ack_cycle_q !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    interrupt_request_input = 1'b0;
    chk(command_delay_select_q === 1'b1 && local_command_enable_q === 1'b1, "ack start");
    n = 0;
    do begin
      tick();
      n++;
      if (cyc_done_q === 1'b1) begin
        dones++;
        if (dones == 1)
          w1 = n;
      end
      if (master_cascade_gate_q === 1'b1) begin
        gates++;
        chk(cascade_addr_oe_q === 1'b1 && cascade_addr_n_q === ~code, "cascade drive");
      end
      if (vector_valid_q === 1'b1) begin
        vv++;
        chk(vector_q === vec, "vector");
      end
      if (bus_request_q === 1'b1 && req_at < 0)
        req_at = n;
      if (sys_buf_en_q === 1'b1 && buf_at < 0)
        buf_at = n;
      if (interrupt_ack_cycle_q === 1'b1 && dones > 0)
        chk(system_resident_bus_select_q === sys && local_command_enable_q === 1'b1,
          "ack choice");
    end while (interrupt_ack_cycle_q === 1'b1 && n < 600);
    chk(dones == 2 && vv == 1 && gates == 2 && bus_request_q === 1'b0
      && command_delay_select_q === 1'b0, "ack shape");
    chk(w1 > MIN_ACK1_WAITS && w1 >= ACK1_WAIT_CYC, "first ack stretch");
    if (sys)
      chk(w1 > ACK1_WAIT_CYC + int'(xack_dly) && req_at > 0 && buf_at > req_at,
        "system ack");
    else
      chk(w1 <= ACK1_WAIT_CYC + 4 && req_at < 0, "local ack");
  endtask

  initial begin
    do_reset(1'b0);
    do_mem(24'h100000, 1'b0, 1'b0);
    do_reset(1'b1);
    do_mem(24'h1fffff, 1'b0, 1'b1);
    do_mem(24'h200000, 1'b0, 1'b0);
    do_mem(24'h000010, 1'b0, 1'b0);
    do_mem(24'h100000, 1'b1, 1'b0);
    do_ack(IRQ_ALL_LOCAL, 3'h5, 1'b0, LOC_RD[7:0]);
    do_ack(IRQ_ALL_SYSTEM, 3'h2, 1'b1, SYS_RD[7:0]);
    do_ack(IRQ_MIXED, 3'h5, 1'b1, SYS_RD[7:0]);
    do_ack(IRQ_MIXED, 3'h2, 1'b0, LOC_RD[7:0]);
    grant_dly = 8'h06;
    xack_dly = 8'h05;
    do_ack(IRQ_MIXED, 3'h5, 1'b1, SYS_RD[7:0]);
    do_mem(24'h1fffff, 1'b0, 1'b1);
    complete_run();
  end
endmodule
